//--- uhis_top.sv
/*
  Interrupt status and enable block of a USB 2.0 host controller, APB slave.
  Assumes event strobes and the threshold tick are one-cycle pulses on pclk;
  port change and resume bits are levels from port logic on pclk.
*/
// The implementer's own choice: the APB register port.
// Behaviour
// - Set frame-wrap flag whenever frame number bit 13 toggles
// - Low flags stay set until a one is written; zero leaves them
// - Set port-change flag on rise of an owned port's change or resume bit
// - Set transaction-error flag when a transaction ends in error
// - Error with interrupt-on-complete sets both error and done flags
// - Set transaction-done flag on completion with interrupt-on-complete
// - Set transaction-done flag on short packet
// - Interrupt only when enable bit and status flag are both set
// - Flags set regardless of enable bits
// - Advance, error and done interrupts wait for the threshold tick
// - System error, wrap and port change interrupt at once
// - Clearing a flag stops its interrupt request
// - After doorbell, set advance flag at next async schedule advance
// - Memory read error sets system-error flag and clears run bit
module uhis_top
  import uhis_pkg::*;
#(
  parameter int NPORTS = 6
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic [UHIS_FRAME_NUMBER_W-1:0]   frame_number,
  input  wire logic [NPORTS-1:0]         port_change,
  input  wire logic [NPORTS-1:0]         port_resume,
  input  wire logic [NPORTS-1:0]         port_owner,
  input  wire logic                      xact_done,
  input  wire logic                      xact_ioc,
  input  wire logic                      xact_error,
  input  wire logic                      short_packet,
  input  wire logic                      async_advance,
  input  wire logic                      mem_read_error,
  input  wire logic                      thresh_tick,
  output logic                           run_out,
  output logic                           irq
);
  import uhis_pkg::*;

  uhis_flag_if fl ();

  // ----------------------------------------------------------------
  // Registered state
  // ----------------------------------------------------------------
  logic [UHIS_NSRC-1:0] enable_reg,   enable_next;
  logic [UHIS_NSRC-1:0] pending_reg,  pending_next;
  logic                 frbit_reg,    frbit_next;
  logic                 frvalid_reg,  frvalid_next;
  logic [NPORTS-1:0]    chg_reg,      chg_next;
  logic [NPORTS-1:0]    res_reg,      res_next;
  logic                 doorbell_reg, doorbell_next;
  logic                 run_reg,      run_next;
  logic                 irq_reg,      irq_next;
  logic [31:0]          prdata_reg,   prdata_next;
  logic                 pslverr_reg,  pslverr_next;

  logic access;
  logic wr_access;
  logic hit;
  logic [UHIS_NSRC-1:0] set_vec;
  logic [UHIS_NSRC-1:0] clr_vec;
  logic [UHIS_NSRC-1:0] active;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // Zero-wait slave: every access completes in its first access cycle
  assign access    = psel & penable;
  assign wr_access = access & pwrite;
  assign hit       = (paddr == UHIS_STATUS_OFF) || (paddr == UHIS_ENABLE_OFF)
                     || (paddr == UHIS_CONTROL_OFF);

  // ----------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------
  always_comb begin
    set_vec = '0;
    set_vec[UHIS_BIT_WRAP]    = frvalid_reg & (frame_number[UHIS_FRAME_NUMBER_WRAP] != frbit_reg);
    set_vec[UHIS_BIT_PORT]    = |(~port_owner & ((port_change & ~chg_reg)
                                                 | (port_resume & ~res_reg)));
    set_vec[UHIS_BIT_ERROR]   = xact_error;
    // done causes; error with ioc sets both
    set_vec[UHIS_BIT_DONE]    = (xact_done & xact_ioc) | (xact_error & xact_ioc) | short_packet;
    set_vec[UHIS_BIT_ADVANCE] = doorbell_reg & async_advance;
    set_vec[UHIS_BIT_SYSERR]  = mem_read_error;
  end

  assign clr_vec = (wr_access && paddr == UHIS_STATUS_OFF) ? pwdata[UHIS_NSRC-1:0] : '0;

  assign fl.set_vec = set_vec;  // enables never gate set_vec
  assign fl.clr_vec = clr_vec;

  uhis_flag_bank u_flags (
    .pclk    (pclk),
    .presetn (presetn),
    .fl      (fl)
  );

  // ----------------------------------------------------------------
  // Next state for history, control and bus registers
  // ----------------------------------------------------------------
  always_comb begin
    frbit_next    = frame_number[UHIS_FRAME_NUMBER_WRAP];
    frvalid_next  = 1'b1;
    chg_next      = port_change;
    res_next      = port_resume;
    enable_next   = enable_reg;
    doorbell_next = doorbell_reg;
    run_next      = run_reg;
    prdata_next   = prdata_reg;
    pslverr_next  = 1'b0;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        UHIS_STATUS_OFF:  prdata_next = {26'h0, fl.flags};
        UHIS_ENABLE_OFF:  prdata_next = {26'h0, enable_reg};
        UHIS_CONTROL_OFF: prdata_next = {30'h0, doorbell_reg, run_reg};
        default:          prdata_next = 32'h0000_0000;
      endcase
    end
    // Error flag raised in setup so that it stands through the access cycle
    if (psel && !penable && !hit) begin
      pslverr_next = 1'b1;
    end
    if (wr_access && paddr == UHIS_ENABLE_OFF) begin
      enable_next = pwdata[UHIS_NSRC-1:0] & UHIS_ENABLE_MASK;
    end
    if (wr_access && paddr == UHIS_CONTROL_OFF) begin
      run_next = pwdata[UHIS_BIT_RUN];
      if (pwdata[UHIS_BIT_DOORBELL]) begin
        doorbell_next = 1'b1;
      end
    end
    // Doorbell self-clears when the advance is reported
    if (set_vec[UHIS_BIT_ADVANCE]) begin
      doorbell_next = 1'b0;
    end
    if (mem_read_error) begin
      run_next = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt forming
  // ----------------------------------------------------------------
  // enable and flag
  assign active = enable_reg & fl.flags;

  always_comb begin
    // held until threshold; dropped when flag cleared
    pending_next = (pending_reg | (thresh_tick ? UHIS_THRESH_SRC : '0)) & active
                   & UHIS_THRESH_SRC;
    // immediate sources plus released gated ones
    // Gated ones are masked by active so a clear drops irq as fast as the rest
    irq_next = |((active & ~UHIS_THRESH_SRC) | (pending_reg & active));
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // enable resets to zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_reg   <= UHIS_ENABLE_RST[UHIS_NSRC-1:0];
      pending_reg  <= '0;
      frbit_reg    <= 1'b0;
      frvalid_reg  <= 1'b0;
      chg_reg      <= '0;
      res_reg      <= '0;
      doorbell_reg <= 1'b0;
      run_reg      <= 1'b0;
      irq_reg      <= 1'b0;
      prdata_reg   <= 32'h0000_0000;
      pslverr_reg  <= 1'b0;
    end else begin
      enable_reg   <= enable_next;
      pending_reg  <= pending_next;
      frbit_reg    <= frbit_next;
      frvalid_reg  <= frvalid_next;
      chg_reg      <= chg_next;
      res_reg      <= res_next;
      doorbell_reg <= doorbell_next;
      run_reg      <= run_next;
      irq_reg      <= irq_next;
      prdata_reg   <= prdata_next;
      pslverr_reg  <= pslverr_next;
    end
  end

  assign prdata  = prdata_reg;
  assign pslverr = pslverr_reg;
  assign pready  = 1'b1;    // Constant ready, counts as a tied flop-free output
  assign run_out = run_reg;
  assign irq     = irq_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_wrap_set;
    @(posedge pclk) disable iff (!presetn)
      (frvalid_reg && frame_number[UHIS_FRAME_NUMBER_WRAP] != frbit_reg)
        |=> fl.flags[UHIS_BIT_WRAP];
  endproperty
  a_wrap_set: assert property (p_wrap_set) else $error("wrap flag not set");

  property p_port_set;
    @(posedge pclk) disable iff (!presetn)
      |(~port_owner & port_change & ~chg_reg) |=> fl.flags[UHIS_BIT_PORT];
  endproperty
  a_port_set: assert property (p_port_set) else $error("port flag not set");

  property p_err_both;
    @(posedge pclk) disable iff (!presetn)
      (xact_error && xact_ioc) |=> (fl.flags[UHIS_BIT_ERROR] && fl.flags[UHIS_BIT_DONE]);
  endproperty
  a_err_both: assert property (p_err_both) else $error("error with ioc not both set");

  property p_short_done;
    @(posedge pclk) disable iff (!presetn)
      short_packet |=> fl.flags[UHIS_BIT_DONE];
  endproperty
  a_short_done: assert property (p_short_done) else $error("short packet lost");

  property p_no_irq_disabled;
    @(posedge pclk) disable iff (!presetn)
      (enable_reg == '0 && $past(enable_reg) == '0 && pending_reg == '0) |-> !irq;
  endproperty
  a_no_irq_disabled: assert property (p_no_irq_disabled) else $error("irq while disabled");

  property p_thresh_wait;
    @(posedge pclk) disable iff (!presetn)
      (pending_reg == '0 && !thresh_tick && (active & ~UHIS_THRESH_SRC) == '0) |=> !irq;
  endproperty
  a_thresh_wait: assert property (p_thresh_wait) else $error("gated irq before tick");

  property p_immediate;
    @(posedge pclk) disable iff (!presetn)
      active[UHIS_BIT_SYSERR] |=> irq;
  endproperty
  a_immediate: assert property (p_immediate) else $error("system error irq late");

  property p_syserr_stop;
    @(posedge pclk) disable iff (!presetn)
      mem_read_error |=> (!run_out && fl.flags[UHIS_BIT_SYSERR]);
  endproperty
  a_syserr_stop: assert property (p_syserr_stop) else $error("system error not handled");

  property p_error_set;
    @(posedge pclk) disable iff (!presetn)
      xact_error |=> fl.flags[UHIS_BIT_ERROR];
  endproperty
  a_error_set: assert property (p_error_set) else $error("error flag not set");

  property p_done_set;
    @(posedge pclk) disable iff (!presetn)
      (xact_done && xact_ioc) |=> fl.flags[UHIS_BIT_DONE];
  endproperty
  a_done_set: assert property (p_done_set) else $error("done flag not set");

  property p_advance_set;
    @(posedge pclk) disable iff (!presetn)
      (doorbell_reg && async_advance) |=> fl.flags[UHIS_BIT_ADVANCE];
  endproperty
  a_advance_set: assert property (p_advance_set) else $error("advance flag not set");

  property p_ack_drop;
    @(posedge pclk) disable iff (!presetn)
      (active == '0) |=> !irq;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("irq held after clear");

  property p_gated_release;
    @(posedge pclk) disable iff (!presetn)
      (pending_reg[UHIS_BIT_DONE] && active[UHIS_BIT_DONE]) |=> irq;
  endproperty
  a_gated_release: assert property (p_gated_release) else $error("released irq missing");

  property p_port_resume;
    @(posedge pclk) disable iff (!presetn)
      |(~port_owner & port_resume & ~res_reg) |=> fl.flags[UHIS_BIT_PORT];
  endproperty
  a_port_resume: assert property (p_port_resume) else $error("resume not flagged");

  property p_wrap_quiet;
    @(posedge pclk) disable iff (!presetn)
      (frvalid_reg && frame_number[UHIS_FRAME_NUMBER_WRAP] == frbit_reg
       && !fl.flags[UHIS_BIT_WRAP]) |=> !fl.flags[UHIS_BIT_WRAP];
  endproperty
  a_wrap_quiet: assert property (p_wrap_quiet) else $error("wrap flag without toggle");
endmodule

//--- uhis_pkg.sv
/*
  Package of the host interrupt status block: register offsets, bit positions,
  reset values and the per-source threshold classification.
  Assumes a 32-bit APB with word-aligned registers.
*/
package uhis_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  UHIS_STATUS_OFF   = 8'h04;
  localparam logic [7:0]  UHIS_ENABLE_OFF   = 8'h08;
  localparam logic [7:0]  UHIS_CONTROL_OFF  = 8'h00;
  localparam logic [31:0] UHIS_ENABLE_RST   = 32'h0000_0000;
  localparam logic [5:0]  UHIS_STATUS_RST   = 6'h00;
  localparam logic [5:0]  UHIS_ENABLE_MASK  = 6'h3f;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int UHIS_NSRC          = 6;
  localparam int UHIS_BIT_DONE      = 0;
  localparam int UHIS_BIT_ERROR     = 1;
  localparam int UHIS_BIT_PORT      = 2;
  localparam int UHIS_BIT_WRAP      = 3;
  localparam int UHIS_BIT_SYSERR    = 4;
  localparam int UHIS_BIT_ADVANCE   = 5;
  localparam int UHIS_BIT_RUN       = 0;
  localparam int UHIS_BIT_DOORBELL  = 1;
  localparam int UHIS_FRAME_NUMBER_WRAP    = 13;
  localparam int UHIS_FRAME_NUMBER_W       = 14;
  // Sources held back to the threshold tick: advance, error, done
  localparam logic [5:0] UHIS_THRESH_SRC = 6'h23;
endpackage

//--- uhis_flag_if.sv
/*
  Interface carrying the per-source set, clear and flag vectors between the
  top and its flag bank. Assumes one clock domain.
*/
interface uhis_flag_if;
  import uhis_pkg::*;
  logic [UHIS_NSRC-1:0] set_vec;
  logic [UHIS_NSRC-1:0] clr_vec;
  logic [UHIS_NSRC-1:0] flags;
  modport ctrl (output set_vec, output clr_vec, input flags);
  modport bank (input set_vec, input clr_vec, output flags);
endinterface

//--- uhis_flag_bank.sv
/*
  Bank of sticky write-one-to-clear status flags, one per source.
  Assumes set and clear vectors are synchronous to pclk.
*/
module uhis_flag_bank
  import uhis_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  uhis_flag_if.bank fl
);
  logic [UHIS_NSRC-1:0] flag_reg;
  logic [UHIS_NSRC-1:0] flag_next;

  // ----------------------------------------------------------------
  // Flag update
  // ----------------------------------------------------------------
  // sticky until write-one
  // Set wins over a same-cycle clear so no event is lost
  always_comb begin
    flag_next = (flag_reg & ~fl.clr_vec) | fl.set_vec;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg <= UHIS_STATUS_RST;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign fl.flags = flag_reg;

  property p_flag_sticky;
    @(posedge pclk) disable iff (!presetn)
      $fell(flag_reg[UHIS_BIT_WRAP]) |-> $past(fl.clr_vec[UHIS_BIT_WRAP]);
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag fell without clear");
endmodule

//--- test_uhis_top.sv
/*
  Directed testbench of the host interrupt status block, driven over APB.
  Assumes event strobes are one-cycle pulses and pready may answer late.
*/
module test_uhis_top;
  timeunit 1ns;
  timeprecision 1ps;
  import uhis_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic                    pclk;
  logic                    presetn;
  logic                    psel;
  logic                    penable;
  logic                    pwrite;
  logic [7:0]              paddr;
  logic [31:0]             pwdata;
  logic [31:0]             prdata;
  logic                    pready;
  logic                    pslverr;
  logic [UHIS_FRAME_NUMBER_W-1:0] frame_number;
  logic [5:0]              port_change;
  logic [5:0]              port_resume;
  logic [5:0]              port_owner;
  logic [6:0]              evt;      // Tick, memerr, adv, short, error, ioc, done
  logic                    run_out;
  logic                    irq;
  logic [31:0]             rd;
  logic                    err;
  int                      error_cnt;
  int                      n_checks;
  logic [6:0]              ev_tab [7] = '{7'h03, 7'h01, 7'h04, 7'h06, 7'h08, 7'h10, 7'h20};
  logic [31:0]             st_tab [7] = '{32'h01, 32'h00, 32'h02, 32'h03, 32'h01, 32'h00, 32'h10};

  uhis_top uut (
    .pclk           (pclk),
    .presetn        (presetn),
    .psel           (psel),
    .penable        (penable),
    .pwrite         (pwrite),
    .paddr          (paddr),
    .pwdata         (pwdata),
    .prdata         (prdata),
    .pready         (pready),
    .pslverr        (pslverr),
    .frame_number   (frame_number),
    .port_change    (port_change),
    .port_resume    (port_resume),
    .port_owner     (port_owner),
    .xact_done      (evt[0]),
    .xact_ioc       (evt[1]),
    .xact_error     (evt[2]),
    .short_packet   (evt[3]),
    .async_advance  (evt[4]),
    .mem_read_error (evt[5]),
    .thresh_tick    (evt[6]),
    .run_out        (run_out),
    .irq            (irq)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // APB transfer; an idle edge at the end keeps two requests from colliding
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  // One-cycle event pulse, returns one edge after it drops
  task automatic pulse(input logic [6:0] v);
    evt <= v;
    @(posedge pclk);
    evt <= 7'h00;
    @(posedge pclk);
  endtask

  // Irq sampled once this edge's updates have landed
  task automatic ci(input logic e);
    #1;
    chk({31'h0, irq}, {31'h0, e});
    @(posedge pclk);
  endtask

  // Rising port bits, then the status read that should follow
  task automatic prise(input logic [5:0] c, input logic [5:0] r, input logic [31:0] e);
    port_change <= c;
    port_resume <= r;
    repeat (3) @(posedge pclk);
    rc(UHIS_STATUS_OFF, e);
    port_change <= 6'h00;
    port_resume <= 6'h00;
    wr(UHIS_STATUS_OFF, 32'h3f);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock and watchdog
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // Whole run is about two hundred cycles, so this bound is generous
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    frame_number = '0;
    port_change = 6'h00;
    port_resume = 6'h00;
    port_owner = 6'h20;              // Port 5 belongs to a companion
    evt = 7'h00;
    error_cnt = 0;
    n_checks = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rc(UHIS_ENABLE_OFF, 32'h0);
    rc(UHIS_STATUS_OFF, 32'h0);
    apb(1'b0, 8'h0c, 32'h0);
    chk({rd[31:1], err}, 32'h1);     // Unmapped: data zero, error flagged
    wr(UHIS_CONTROL_OFF, 32'h1);
    rc(UHIS_CONTROL_OFF, 32'h1);
    // Each strobe pattern in ev_tab with all enables off: flag only, no irq
    for (int i = 0; i < 7; i++) begin
      pulse(ev_tab[i]);
      rc(UHIS_STATUS_OFF, st_tab[i]);
      chk({31'h0, irq}, 32'h0);
      wr(UHIS_STATUS_OFF, 32'h3f);
    end
    chk({31'h0, run_out}, 32'h0);
    pulse(7'h03);
    wr(UHIS_STATUS_OFF, 32'h2);
    rc(UHIS_STATUS_OFF, 32'h1);
    wr(UHIS_STATUS_OFF, 32'h1);
    rc(UHIS_STATUS_OFF, 32'h0);
    wr(UHIS_CONTROL_OFF, 32'h2);
    pulse(7'h10);
    rc(UHIS_STATUS_OFF, 32'h20);
    rc(UHIS_CONTROL_OFF, 32'h0);
    wr(UHIS_STATUS_OFF, 32'h20);
    frame_number <= 14'h1000;        // Bit 12 alone is no wrap
    repeat (2) @(posedge pclk);
    rc(UHIS_STATUS_OFF, 32'h0);
    frame_number <= 14'h2000;
    repeat (2) @(posedge pclk);
    rc(UHIS_STATUS_OFF, 32'h8);
    wr(UHIS_STATUS_OFF, 32'h8);
    prise(6'h01, 6'h00, 32'h4);
    prise(6'h20, 6'h00, 32'h0);
    prise(6'h00, 6'h02, 32'h4);
    wr(UHIS_ENABLE_OFF, 32'h3f);
    rc(UHIS_ENABLE_OFF, 32'h3f);
    // Wrap interrupts without a threshold tick
    frame_number <= 14'h0000;
    repeat (2) @(posedge pclk);
    ci(1'b1);
    wr(UHIS_STATUS_OFF, 32'h8);
    ci(1'b0);
    // Done waits for the threshold tick
    pulse(7'h03);
    repeat (4) @(posedge pclk);
    ci(1'b0);
    pulse(7'h40);
    ci(1'b1);
    wr(UHIS_STATUS_OFF, 32'h1);
    ci(1'b0);
    wr(UHIS_ENABLE_OFF, 32'h3e);
    pulse(7'h03);
    pulse(7'h40);
    ci(1'b0);
    rc(UHIS_STATUS_OFF, 32'h1);
    pulse(7'h20);
    ci(1'b1);
    wr(UHIS_STATUS_OFF, 32'h10);
    ci(1'b0);
    tally_and_finish();
  end
endmodule
